// [inc/scr_map.vh]
// scr_map.vh: offsets, field positions, reset values and counts of the
// system control register bank.
// assumes: included by bare name from the logic files; definitions only.
`ifndef SCR_MAP_VH
`define SCR_MAP_VH

// ****************************************************************
// register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define SCR_OFS_BOOT        8'h00
`define SCR_OFS_RST         8'h04
`define SCR_OFS_LPWR        8'h08
`define SCR_OFS_CLK         8'h0C
`define SCR_OFS_PADS        8'h14
`define SCR_OFS_DBG         8'h1C
`define SCR_OFS_WRISE       8'h20
`define SCR_OFS_WFALL       8'h24
`define SCR_OFS_WPEND       8'h28

// ****************************************************************
// reset_cause_control fields
// ****************************************************************
`define SCR_RST_FLAG_HI     31
`define SCR_RST_FLAG_LO     25
`define SCR_RST_CLR_BIT     24
`define SCR_EXT_LOGIC_RESET_ALLOW_BIT  1
`define SCR_RST_SW_BIT      0
// flag order from bit 25 upward: ext, pad, poweron, sw, indep dog, window dog, low power
`define SCR_FLAG_EXT        0
`define SCR_FLAG_PAD        1
`define SCR_FLAG_POR        2
`define SCR_FLAG_SW         3
`define SCR_FLAG_IDOG       4
`define SCR_FLAG_WDOG       5
`define SCR_FLAG_LPWR       6
`define SCR_FLAGS_RESET     7'h04

// ****************************************************************
// low power, clock, debug and wake fields
// ****************************************************************
`define SCR_LP_SLEEP        2'h0
`define SCR_LP_STOP         2'h1
`define SCR_LP_STANDBY      2'h3
`define SCR_CLK_DIVH_HI     15
`define SCR_CLK_DIVH_LO     12
`define SCR_CLK_DIVL_HI     11
`define SCR_CLK_DIVL_LO     8
`define SCR_CLK_PLL_RDY     6
`define SCR_CLK_PLL_ON      5
`define SCR_CLK_XTAL_RDY    4
`define SCR_CLK_XTAL_BYP    3
`define SCR_CLK_XTAL_ON     2
`define SCR_DBG_RTC_BIT     4
`define SCR_DBG_IDOG_BIT    3
`define SCR_WAKE_ALARM_BIT  8

// ****************************************************************
// counts
// ****************************************************************
`define SCR_STRAP_EDGE      3'h4
`define SCR_SYNC_LINES      9

`endif

// [logic/scr_sync_edge.v]
// scr_sync_edge.v: two-flop synchroniser with edge detection per line.
// assumes: lines come from pads or other clocks; outputs are on clk_in.
`timescale 1ns/1ns
`default_nettype none

module scr_sync_edge
#(
  parameter N = 9
)
(
  input  wire         clk_in,
  input  wire         resetn_in,
  input  wire [N-1:0] lines_in,
  output wire [N-1:0] level_out,
  output wire [N-1:0] rise_out,
  output wire [N-1:0] fall_out
);

  // ****************************************************************
  // per line: meta flop, stable flop, previous value
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_line
      reg meta_r;
      reg stable_r;
      reg prev_r;
      // only stable_r reads meta_r, so metastability never reaches logic
      always @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
          prev_r   <= 1'b0;
        end
        else
        begin
          meta_r   <= lines_in[i];
          stable_r <= meta_r;
          prev_r   <= stable_r;
        end
      end
      assign level_out[i] = stable_r;
      assign rise_out[i]  = stable_r & ~prev_r;
      assign fall_out[i]  = ~stable_r & prev_r;
    end
  endgenerate

endmodule // scr_sync_edge

`default_nettype wire

// [logic/scr_regs.v]
// scr_regs.v: system control register bank (boot strap, reset causes,
// low power select, clock control, debug pad reuse, debug halt, wake).
// assumes: one clock; resetn_in is the power-on reset of this bank, so
// the cause flags survive the system resets that this bank requests.
`timescale 1ns/1ns
`default_nettype none
`include "scr_map.vh"

// How it works
// (R1) strap pins are latched on the 4th clock edge after reset release
// (R2) boot word at 0x00 returns latched strap pair in bits 1:0, read only
// (R3) sticky cause flags in bits 31:25, one per reset source, read one when seen
// (R4) writing one to bit 24 clears every cause flag together
// (R5) external logic reset request acts only while bit 1 is one
// (R6) writing one to bit 0 starts a software reset and sets flag bit 28
// (R7) low power field at 0x08 picks sleep, stop or standby on wait for interrupt
// (R8) flash serial clock tick every high divider value plus one cycles
// (R9) software keeps the low divider field equal to the high one
// (R10) bit 5 switches the pll; bit 6 reads one once the pll is ready
// (R11) bit 2 powers crystal, bit 3 bypasses it, bit 4 shows it ready
// (R12) bits 0 to 4 at 0x14 free the five debug pads as user pins
// (R13) in debug, bit 4 halts the rtc and bit 3 halts the watchdog
// (R14) 0x20 bits 7:0 pick rising edge wake, bit 8 picks rtc alarm wake
// (R15) 0x24 bits 7:0 pick falling edge wake for the eight lines
// (R16) a selected wake event sets its pending bit at 0x28
// (R17) writes to ready bits and boot field are ignored
module scr_regs
#(
  parameter AW = 8
)
(
  input  wire          clk_in,
  input  wire          resetn_in,
  // register port
  input  wire [AW-1:0] addr_in,
  input  wire [31:0]   wdata_in,
  input  wire          wr_in,
  input  wire          rd_in,
  output reg  [31:0]   rdata_out,
  // strap pins and reset sources (asynchronous)
  input  wire          strap_pin_low_in,
  input  wire          strap_pin_high_in,
  input  wire          lowpower_rst_in,
  input  wire          window_dog_rst_in,
  input  wire          indep_dog_rst_in,
  input  wire          reset_pad_rst_in,
  input  wire          ext_logic_rst_req_in,
  output wire          sys_reset_out,
  // low power
  input  wire          wfi_in,
  output wire          enter_sleep_out,
  output wire          enter_stop_out,
  output wire          enter_standby_out,
  // clocks
  input  wire          xtal_stable_in,
  input  wire          pll_ready_in,
  output wire          xtal_power_request_out,
  output wire          xtal_bypass_out,
  output wire          pll_on_out,
  output wire          flash_sclk_tick_out,
  // debug
  input  wire          core_in_debug_in,
  output wire          tap_clock_pad_reuse_out,
  output wire          tap_select_pad_reuse_out,
  output wire          tap_in_pad_reuse_out,
  output wire          tap_out_pad_reuse_out,
  output wire          tap_reset_pad_reuse_out,
  output wire          rtc_halt_out,
  output wire          indep_dog_halt_out,
  // wake
  input  wire [7:0]    ext_wake_lines_in,
  input  wire          rtc_alarm_in,
  output wire          wake_out
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  wire [8:0] st_lvl;
  wire [8:0] st_rise;
  // wake line levels are not needed; only their edges set pending bits
  wire [8:0] wk_rise;
  wire [8:0] wk_fall;

  // status and cause lines: 0..4 causes, 5 xtal, 6 pll, 7..8 straps
  scr_sync_edge #(.N(`SCR_SYNC_LINES)) u_status_sync
  (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .lines_in  ({strap_pin_high_in, strap_pin_low_in, pll_ready_in, xtal_stable_in,
                 ext_logic_rst_req_in, reset_pad_rst_in, indep_dog_rst_in,
                 window_dog_rst_in, lowpower_rst_in}),
    .level_out (st_lvl),
    .rise_out  (st_rise),
    .fall_out  ()
  );

  // wake lines: eight external lines plus rtc alarm on top
  scr_sync_edge #(.N(`SCR_SYNC_LINES)) u_wake_sync
  (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .lines_in  ({rtc_alarm_in, ext_wake_lines_in}),
    .level_out (),
    .rise_out  (wk_rise),
    .fall_out  (wk_fall)
  );

  // ****************************************************************
  // register state
  // ****************************************************************
  reg  [2:0]  strap_cnt_r;
  reg  [1:0]  boot_r;
  reg  [6:0]  flags_r;
  reg  [6:0]  flags_nxt;
  reg         ext_allow_r;
  reg         sys_rst_r;
  reg  [1:0]  lp_sel_r;
  reg  [3:0]  div_high_r;
  reg  [3:0]  div_low_r;
  reg         pll_on_r;
  reg         xtal_on_r;
  reg         xtal_byp_r;
  reg  [4:0]  pads_r;
  reg         dbg_rtc_r;
  reg         dbg_idog_r;
  reg  [8:0]  wrise_r;
  reg  [7:0]  wfall_r;
  reg  [8:0]  wpend_r;
  reg  [8:0]  wpend_nxt;
  reg  [3:0]  div_cnt_r;
  reg  [31:0] rdata_nxt;

  wire wr_rst   = wr_in && (addr_in == `SCR_OFS_RST);
  wire sw_kick  = wr_rst && wdata_in[`SCR_RST_SW_BIT];
  wire ext_kick = st_rise[4] && ext_allow_r; // R5

  // ****************************************************************
  // boot strap capture
  // ****************************************************************
  // counter restarts after power-on release and after each system reset
  // pulse; pins seen here are two cycles old because of the synchroniser
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      strap_cnt_r <= 3'h0;
      boot_r      <= 2'h0;
    end
    else if (sys_rst_r)
    begin
      strap_cnt_r <= 3'h0;
    end
    else if (strap_cnt_r != `SCR_STRAP_EDGE)
    begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
      if (strap_cnt_r == `SCR_STRAP_EDGE - 3'h1)
        boot_r <= st_lvl[8:7]; // R1
    end
  end

  // ****************************************************************
  // reset cause flags and reset request
  // ****************************************************************
  // clear first, then sets, so an event in the clearing cycle survives
  always @*
  begin
    flags_nxt = flags_r;
    if (wr_rst && wdata_in[`SCR_RST_CLR_BIT])
      flags_nxt = 7'h00; // R4
    if (st_rise[0])
      flags_nxt[`SCR_FLAG_LPWR] = 1'b1; // R3
    if (st_rise[1])
      flags_nxt[`SCR_FLAG_WDOG] = 1'b1; // R3
    if (st_rise[2])
      flags_nxt[`SCR_FLAG_IDOG] = 1'b1; // R3
    if (st_rise[3])
      flags_nxt[`SCR_FLAG_PAD] = 1'b1; // R3
    if (ext_kick)
      flags_nxt[`SCR_FLAG_EXT] = 1'b1; // R3
    if (sw_kick)
      flags_nxt[`SCR_FLAG_SW] = 1'b1; // R6
  end

  // power-on flag is set by the reset value itself
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      flags_r     <= `SCR_FLAGS_RESET;
      ext_allow_r <= 1'b0;
      sys_rst_r   <= 1'b0;
    end
    else
    begin
      flags_r   <= flags_nxt;
      sys_rst_r <= sw_kick | ext_kick; // R5 R6
      if (wr_rst)
        ext_allow_r <= wdata_in[`SCR_EXT_LOGIC_RESET_ALLOW_BIT]; // R5
    end
  end

  assign sys_reset_out = sys_rst_r;

  // ****************************************************************
  // plain control registers
  // ****************************************************************
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      lp_sel_r   <= `SCR_LP_SLEEP;
      div_high_r <= 4'h0;
      div_low_r  <= 4'h0;
      pll_on_r   <= 1'b0;
      xtal_on_r  <= 1'b0;
      xtal_byp_r <= 1'b0;
      pads_r     <= 5'h00;
      dbg_rtc_r  <= 1'b0;
      dbg_idog_r <= 1'b0;
      wrise_r    <= 9'h000;
      wfall_r    <= 8'h00;
    end
    else if (wr_in)
    begin
      case (addr_in)
        `SCR_OFS_LPWR:
          lp_sel_r <= wdata_in[1:0]; // R7
        `SCR_OFS_CLK:
        begin
          // ready bits are not stored; they come from the pins
          div_high_r <= wdata_in[`SCR_CLK_DIVH_HI:`SCR_CLK_DIVH_LO]; // R8
          div_low_r  <= wdata_in[`SCR_CLK_DIVL_HI:`SCR_CLK_DIVL_LO]; // R9
          pll_on_r   <= wdata_in[`SCR_CLK_PLL_ON]; // R10
          xtal_on_r  <= wdata_in[`SCR_CLK_XTAL_ON]; // R11
          xtal_byp_r <= wdata_in[`SCR_CLK_XTAL_BYP]; // R11
        end
        `SCR_OFS_PADS:
          pads_r <= wdata_in[4:0]; // R12
        `SCR_OFS_DBG:
        begin
          dbg_rtc_r  <= wdata_in[`SCR_DBG_RTC_BIT]; // R13
          dbg_idog_r <= wdata_in[`SCR_DBG_IDOG_BIT]; // R13
        end
        `SCR_OFS_WRISE:
          wrise_r <= wdata_in[8:0]; // R14
        `SCR_OFS_WFALL:
          wfall_r <= wdata_in[7:0]; // R15
        default:
          wrise_r <= wrise_r;
      endcase
    end
  end

  // ****************************************************************
  // low power entry
  // ****************************************************************
  // the unlisted code 10 enters nothing, so the core just keeps running
  assign enter_sleep_out   = wfi_in && (lp_sel_r == `SCR_LP_SLEEP); // R7
  assign enter_stop_out    = wfi_in && (lp_sel_r == `SCR_LP_STOP); // R7
  assign enter_standby_out = wfi_in && (lp_sel_r == `SCR_LP_STANDBY); // R7

  // ****************************************************************
  // clocks and flash serial clock divider
  // ****************************************************************
  assign xtal_power_request_out = xtal_on_r; // R11
  assign xtal_bypass_out        = xtal_byp_r; // R11
  assign pll_on_out             = pll_on_r; // R10

  // a tick rather than a divided clock: divide by one must still work
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      div_cnt_r <= 4'h0;
    else if (div_cnt_r >= div_high_r)
      div_cnt_r <= 4'h0; // R8
    else
      div_cnt_r <= div_cnt_r + 4'h1;
  end

  assign flash_sclk_tick_out = (div_cnt_r >= div_high_r); // R8

  // ****************************************************************
  // debug pads and halts
  // ****************************************************************
  assign tap_clock_pad_reuse_out  = pads_r[0]; // R12
  assign tap_select_pad_reuse_out = pads_r[1]; // R12
  assign tap_in_pad_reuse_out     = pads_r[2]; // R12
  assign tap_out_pad_reuse_out    = pads_r[3]; // R12
  assign tap_reset_pad_reuse_out  = pads_r[4]; // R12
  assign rtc_halt_out       = core_in_debug_in && dbg_rtc_r; // R13
  assign indep_dog_halt_out = core_in_debug_in && dbg_idog_r; // R13

  // ****************************************************************
  // wake pending
  // ****************************************************************
  // write one clears a bit; a new event in the same cycle wins
  always @*
  begin
    wpend_nxt = wpend_r;
    if (wr_in && (addr_in == `SCR_OFS_WPEND))
      wpend_nxt = wpend_r & ~wdata_in[8:0];
    wpend_nxt = wpend_nxt | (wk_rise & wrise_r) | ({1'b0, wk_fall[7:0]} & {1'b0, wfall_r}); // R16
  end

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wpend_r <= 9'h000;
    else
      wpend_r <= wpend_nxt; // R16
  end

  assign wake_out = |wpend_r;

  // ****************************************************************
  // read path, one cycle after the strobe
  // ****************************************************************
  // unmapped offsets and reserved bits read zero
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (addr_in)
      `SCR_OFS_BOOT:
        rdata_nxt[1:0] = boot_r; // R2 R17
      `SCR_OFS_RST:
      begin
        rdata_nxt[`SCR_RST_FLAG_HI:`SCR_RST_FLAG_LO] = flags_r; // R3
        rdata_nxt[`SCR_EXT_LOGIC_RESET_ALLOW_BIT] = ext_allow_r;
      end
      `SCR_OFS_LPWR:
        rdata_nxt[1:0] = lp_sel_r;
      `SCR_OFS_CLK:
      begin
        rdata_nxt[`SCR_CLK_DIVH_HI:`SCR_CLK_DIVH_LO] = div_high_r;
        rdata_nxt[`SCR_CLK_DIVL_HI:`SCR_CLK_DIVL_LO] = div_low_r;
        rdata_nxt[`SCR_CLK_PLL_RDY]  = st_lvl[6]; // R10 R17
        rdata_nxt[`SCR_CLK_PLL_ON]   = pll_on_r;
        rdata_nxt[`SCR_CLK_XTAL_RDY] = st_lvl[5]; // R11 R17
        rdata_nxt[`SCR_CLK_XTAL_BYP] = xtal_byp_r;
        rdata_nxt[`SCR_CLK_XTAL_ON]  = xtal_on_r;
      end
      `SCR_OFS_PADS:
        rdata_nxt[4:0] = pads_r;
      `SCR_OFS_DBG:
      begin
        rdata_nxt[`SCR_DBG_RTC_BIT]  = dbg_rtc_r;
        rdata_nxt[`SCR_DBG_IDOG_BIT] = dbg_idog_r;
      end
      `SCR_OFS_WRISE:
        rdata_nxt[8:0] = wrise_r;
      `SCR_OFS_WFALL:
        rdata_nxt[7:0] = wfall_r;
      `SCR_OFS_WPEND:
        rdata_nxt[8:0] = wpend_r;
      default:
        rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_out <= 32'h0000_0000;
    else if (rd_in)
      rdata_out <= rdata_nxt;
    else
      rdata_out <= 32'h0000_0000;
  end

endmodule // scr_regs

`default_nettype wire

// [dv/scr_regs_properties.sv]
// scr_regs_properties.sv: port-level assertions for the register bank.
// assumes: bound into scr_regs; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module scr_regs_properties
#(
  parameter AW = 8
)
(
  input wire logic          clk_in,
  input wire logic          resetn_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [31:0]   wdata_in,
  input wire logic          wr_in,
  input wire logic          rd_in,
  input wire logic [31:0]   rdata_out,
  input wire logic          sys_reset_out,
  input wire logic          wfi_in,
  input wire logic          enter_sleep_out,
  input wire logic          enter_stop_out,
  input wire logic          enter_standby_out,
  input wire logic          xtal_power_request_out,
  input wire logic          xtal_bypass_out,
  input wire logic          pll_on_out,
  input wire logic          flash_sclk_tick_out,
  input wire logic          core_in_debug_in,
  input wire logic          rtc_halt_out,
  input wire logic          indep_dog_halt_out,
  input wire logic          tap_clock_pad_reuse_out,
  input wire logic          tap_reset_pad_reuse_out
);
  // ********
  // assertions
  // ********
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  AST_SW_PULSE: assert property (wr_in && addr_in == 8'h04 && wdata_in[0] |=> sys_reset_out)
    else $error("software reset write gave no reset request");
  AST_CLK_WRITE: assert property (wr_in && addr_in == 8'h0C |=>
    {pll_on_out, xtal_bypass_out, xtal_power_request_out} == {$past(wdata_in[5]), $past(wdata_in[3]), $past(wdata_in[2])})
    else $error("clock control outputs differ from written bits");
  // divide by one means a tick in every cycle
  AST_DIV_ONE: assert property (wr_in && addr_in == 8'h0C && wdata_in[15:12] == 4'h0 |=> flash_sclk_tick_out)
    else $error("flash tick missing with divider zero");
  AST_LP_CAUSE: assert property (enter_sleep_out || enter_stop_out || enter_standby_out |-> wfi_in)
    else $error("low power entry without wait for interrupt");
  AST_LP_STOP: assert property (wr_in && addr_in == 8'h08 && wdata_in[1:0] == 2'h1 ##1 wfi_in |->
    enter_stop_out && !enter_sleep_out && !enter_standby_out)
    else $error("stop code did not select stop entry");
  AST_HALT_CAUSE: assert property (rtc_halt_out || indep_dog_halt_out |-> core_in_debug_in)
    else $error("halt outside debug");
  AST_DBG_HALT: assert property (wr_in && addr_in == 8'h1C ##1 core_in_debug_in |->
    rtc_halt_out == $past(wdata_in[4]) && indep_dog_halt_out == $past(wdata_in[3]))
    else $error("debug halt outputs differ from written bits");
  AST_PADS: assert property (wr_in && addr_in == 8'h14 |=>
    tap_clock_pad_reuse_out == $past(wdata_in[0]) && tap_reset_pad_reuse_out == $past(wdata_in[4]))
    else $error("pad reuse outputs differ from written bits");
  AST_BOOT_RO: assert property (rd_in && addr_in == 8'h00 |=> rdata_out[31:2] == 30'h0)
    else $error("reserved boot bits read nonzero");
endmodule // scr_regs_properties

bind scr_regs scr_regs_properties #(.AW(AW)) scr_regs_properties_i
(
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .sys_reset_out(sys_reset_out), .wfi_in(wfi_in),
  .enter_sleep_out(enter_sleep_out), .enter_stop_out(enter_stop_out), .enter_standby_out(enter_standby_out),
  .xtal_power_request_out(xtal_power_request_out), .xtal_bypass_out(xtal_bypass_out),
  .pll_on_out(pll_on_out), .flash_sclk_tick_out(flash_sclk_tick_out), .core_in_debug_in(core_in_debug_in),
  .rtc_halt_out(rtc_halt_out), .indep_dog_halt_out(indep_dog_halt_out),
  .tap_clock_pad_reuse_out(tap_clock_pad_reuse_out), .tap_reset_pad_reuse_out(tap_reset_pad_reuse_out)
);
`default_nettype wire

// [dv/tb_top.sv]
// tb_top.sv: self-checking bench for the system control register bank.
// assumes: scr_regs and the checker are compiled alongside; one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ********
  // signals
  // ********
  logic        clk, rstn, wr, rd, slo, shi, wfi, xrdy, prdy, dbg, alarm, ext, rd_d;
  logic        sysrst, slp, stp, sby, xon, xbyp, pllon, tick, rtch, idh, wake;
  logic [3:0]  rsrc;
  logic [4:0]  pads;
  logic [7:0]  addr, lines;
  logic [31:0] wdata, rdata, w, e;
  logic [31:0] exp_q[$];
  int          bad_count, n_checks, rst_cnt, tk;
  int          fb[4] = '{26, 29, 30, 31};
  logic [2:0]  lpx[4] = '{3'b001, 3'b010, 3'b000, 3'b100};

  scr_regs #(.AW(8)) scr_regs_i
  (
    .clk_in(clk), .resetn_in(rstn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .strap_pin_low_in(slo), .strap_pin_high_in(shi),
    .lowpower_rst_in(rsrc[3]), .window_dog_rst_in(rsrc[2]), .indep_dog_rst_in(rsrc[1]),
    .reset_pad_rst_in(rsrc[0]), .ext_logic_rst_req_in(ext), .sys_reset_out(sysrst), .wfi_in(wfi),
    .enter_sleep_out(slp), .enter_stop_out(stp), .enter_standby_out(sby), .xtal_stable_in(xrdy),
    .pll_ready_in(prdy), .xtal_power_request_out(xon), .xtal_bypass_out(xbyp), .pll_on_out(pllon),
    .flash_sclk_tick_out(tick), .core_in_debug_in(dbg), .tap_clock_pad_reuse_out(pads[0]),
    .tap_select_pad_reuse_out(pads[1]), .tap_in_pad_reuse_out(pads[2]), .tap_out_pad_reuse_out(pads[3]),
    .tap_reset_pad_reuse_out(pads[4]), .rtc_halt_out(rtch), .indep_dog_halt_out(idh),
    .ext_wake_lines_in(lines), .rtc_alarm_in(alarm), .wake_out(wake)
  );

  // ********
  // clock, monitors, tasks
  // ********
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // read data stand only in the cycle after the strobe, so compare at its falling edge
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (sysrst === 1'b1)
      rst_cnt++;
  end
  always @(negedge clk)
    if (rd_d === 1'b1)
      chk(rdata, exp_q.pop_front());

  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    n_checks++;
    if (got !== ex)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, ex);
    end
  endtask

  // one bus cycle; for a read the data word is the expected answer
  task automatic bus(input logic w1, input logic r1, input logic [7:0] a, input logic [31:0] d);
    wr <= w1;
    rd <= r1;
    addr <= a;
    wdata <= d;
    if (r1)
      exp_q.push_back(d);
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, addr, wdata);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // cut a hang short well past the expected few hundred cycles
  initial
  begin
    #2000000;
    bad_count++;
    complete_run;
  end

  // ********
  // scenarios
  // ********
  initial
  begin
    {rstn, wr, rd, slo, wfi, xrdy, prdy, dbg, alarm, ext, rd_d} = '0;
    shi = 1'b1;
    rsrc = 4'h0;
    lines = 8'h00;
    addr = 8'h00;
    wdata = 32'h0;
    void'($urandom(32'hA441B7C8));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(0, 1, 8'h00, 32'h0);
    idle(1);
    bus(0, 1, 8'h00, 32'h0);
    bus(0, 1, 8'h00, 32'h2);
    bus(1, 0, 8'h00, 32'hFFFFFFFF);
    bus(0, 1, 8'h00, 32'h2);
    bus(0, 1, 8'h04, 32'h08000000);
    bus(1, 0, 8'h10, 32'hFFFFFFFF);
    foreach (lpx[i])
      bus(0, 1, (i < 2) ? 8'h08 + 8'(4 * i) : 8'h14 + 8'(8 * (i - 2)), 32'h0);
    bus(0, 1, 8'h10, 32'h0);
    // each pad, dog and low power cause source sets its own sticky flag, then one write clears all
    e = 32'h08000000;
    for (int i = 0; i < 4; i++)
    begin
      rsrc[i] <= 1'b1;
      idle(2);
      rsrc[i] <= 1'b0;
      idle(3);
      e = e | (32'h1 << fb[i]);
      bus(0, 1, 8'h04, e);
    end
    bus(1, 0, 8'h04, 32'h01000000);
    bus(0, 1, 8'h04, 32'h0);
    // external request blocked, then allowed
    ext <= 1'b1;
    idle(5);
    ext <= 1'b0;
    bus(1, 0, 8'h04, 32'h2);
    #1 chk(rst_cnt, 0);
    ext <= 1'b1;
    idle(5);
    ext <= 1'b0;
    bus(0, 1, 8'h04, 32'h02000002);
    #1 chk(rst_cnt, 1);
    bus(1, 0, 8'h04, 32'h01000003);
    idle(1);
    #1 chk(rst_cnt, 2);
    bus(0, 1, 8'h04, 32'h10000002);
    // every low power code against the three entry outputs
    for (int i = 0; i < 4; i++)
    begin
      bus(1, 0, 8'h08, 32'(i));
      wfi <= 1'b1;
      idle(1);
      #1 chk({sby, stp, slp}, lpx[i]);
      wfi <= 1'b0;
      bus(0, 1, 8'h08, 32'(i));
    end
    // divider: zero, three, then random; ready inputs disagree with written bits
    for (int k = 0; k < 3; k++)
    begin
      w = (k == 0) ? 32'h0 : (k == 1) ? 32'h3 : $urandom % 16;
      w = (w << 12) | (w << 8) | ($urandom & 32'h7C);
      xrdy <= ~w[4];
      prdy <= ~w[6];
      bus(1, 0, 8'h0C, w);
      idle(17);
      #1 chk({pllon, xbyp, xon}, {w[5], w[3], w[2]});
      tk = 0;
      repeat (4 * (w[15:12] + 1))
      begin
        @(negedge clk);
        tk += int'(tick === 1'b1);
      end
      @(posedge clk);
      chk(tk, 4);
      bus(0, 1, 8'h0C, (w ^ 32'h50) & 32'hFF7C);
    end
    repeat (2)
    begin
      w = $urandom & 32'h1F;
      bus(1, 0, 8'h14, w);
      #1 chk(pads, w[4:0]);
      bus(0, 1, 8'h14, w);
    end
    for (int i = 0; i < 8; i++)
    begin
      dbg <= i[0];
      bus(1, 0, 8'h1C, {27'h0, i[2:1], 3'h0});
      #1 chk({rtch, idh}, {i[2] & i[0], i[1] & i[0]});
    end
    // wake: unselected edges ignored, selected ones pend until cleared
    bus(1, 0, 8'h20, 32'h101);
    bus(1, 0, 8'h24, 32'h2);
    lines <= 8'h04;
    idle(4);
    #1 chk(wake, 1'b0);
    lines <= 8'h05;
    idle(4);
    bus(0, 1, 8'h28, 32'h1);
    #1 chk(wake, 1'b1);
    bus(1, 0, 8'h28, 32'h1FF);
    lines <= 8'h07;
    idle(4);
    lines <= 8'h05;
    idle(4);
    bus(0, 1, 8'h28, 32'h2);
    bus(1, 0, 8'h28, 32'h1FF);
    alarm <= 1'b1;
    idle(4);
    bus(0, 1, 8'h28, 32'h100);
    bus(1, 0, 8'h28, 32'h1FF);
    idle(2);
    #1 chk(wake, 1'b0);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
